// ---- logic/cfg_word_pkg.sv ----
package cfg_word_pkg;

    // Register word addresses on the bus (byte offsets)
    localparam logic [3:0] ADDR_CFG_WORD_0   = 4'h0;
    localparam logic [3:0] ADDR_CFG_WORD_1   = 4'h4;
    localparam logic [3:0] ADDR_CFG_WORD_2   = 4'h8;
    localparam logic [3:0] ADDR_CFG_WORD_3   = 4'hC;
    localparam logic [5:0] ADDR_RUNTIME_CTRL = 6'h10;
    localparam logic [5:0] ADDR_UNLOCK       = 6'h14;
    localparam int         ADDR_W            = 6;

    // Unlock key pair written in order to the unlock register
    localparam logic [31:0] UNLOCK_KEY_A = 32'hAA99_6655;
    localparam logic [31:0] UNLOCK_KEY_B = 32'h5566_99AA;

    // Word 0 field
    localparam int W0_TEST_PORT_EN  = 2;
    // Word 1 fields
    localparam int W1_WIN_SIZE_LO   = 24;
    localparam int W1_WDOG_EN       = 23;
    localparam int W1_WIN_DIS       = 22;
    localparam int W1_POSTSCALE_LO  = 16;
    localparam int W1_CKSM_LO       = 14;
    localparam int W1_PBDIV_LO      = 12;
    localparam int W1_CLKOUT_DIS    = 10;
    localparam int W1_POSC_LO       = 8;
    localparam int W1_TWO_SPEED     = 7;
    localparam int W1_SOSC_EN       = 5;
    localparam int W1_OSC_SEL_LO    = 0;
    // Word 2 fields
    localparam int W2_PLL_ODIV_LO   = 16;
    localparam int W2_USB_PLL_DIS   = 15;
    localparam int W2_USB_IDIV_LO   = 8;
    localparam int W2_PLL_MUL_LO    = 4;
    localparam int W2_PLL_IDIV_LO   = 0;
    // Word 3 fields
    localparam int W3_VBUS_OWNER    = 31;
    localparam int W3_ID_OWNER      = 30;
    localparam int W3_PPS_ONE_WAY   = 29;
    localparam int W3_PMD_ONE_WAY   = 28;
    localparam int W3_SRS_LO        = 16;
    localparam int W3_USERID_LO     = 0;
    // Runtime control fields
    localparam int RC_PPS_LOCK      = 13;
    localparam int RC_PMD_LOCK      = 12;
    localparam int RC_TEST_PORT_EN  = 3;
    localparam int RC_TRACE_EN      = 2;
    localparam int RC_TDO_USE       = 0;

    localparam logic [4:0]  POSTSCALE_MAX  = 5'h14;
    localparam logic [1:0]  POSC_DISABLED  = 2'h3;
    localparam logic [1:0]  POSC_EXT_CLOCK = 2'h0;
    localparam logic [31:0] RC_WRITE_MASK  = 32'h0000_300D;
    localparam logic [31:0] BUS_UNMAPPED   = 32'h0000_0000;

    typedef enum logic [2:0] {
        SRC_FAST_RC, SRC_FAST_RC_PLL, SRC_PRIMARY, SRC_PRIMARY_PLL,
        SRC_SECONDARY, SRC_LOW_POWER_RC, SRC_FAST_RC_DIV16, SRC_FAST_RC_DIV_N
    } osc_src_e;

    typedef enum logic [1:0] {
        POSC_EXT, POSC_STD_XTAL, POSC_HS_XTAL, POSC_OFF
    } posc_mode_e;

    typedef enum logic [1:0] {
        LOAD_IDLE, LOAD_RUN
    } load_state_e;

    typedef struct packed {
        logic        wdog_hw_enable;   // runs, software cannot stop
        logic        wdog_sw_may_enable;
        logic        wdog_windowed;
        logic [6:0]  wdog_window_pct_x2; // 2x percent: 50,75,100,150
        logic [4:0]  wdog_postscale_log2;
        logic        clk_switch_en;
        logic        fail_safe_mon_en;
        logic [3:0]  periph_bus_div;
        logic        clock_output_en;
        posc_mode_e  primary_osc_mode;
        logic        two_speed_startup_en;
        logic        secondary_osc_en;
        osc_src_e    initial_osc_select;
        logic [8:0]  pll_out_div;
        logic        usb_pll_bypass;
        logic [3:0]  usb_pll_in_div;
        logic [3:0]  pll_in_div;
        logic [4:0]  pll_multiplier;
        logic        usb_bus_power_to_usb;
        logic        usb_id_to_usb;
        logic        pin_select_one_way;
        logic        module_disable_one_way;
        logic [2:0]  shadow_set_priority;
        logic [15:0] user_ident_value;
    } cfg_out_s;

    typedef struct packed {
        logic pin_select_lock;
        logic module_disable_lock;
        logic test_port_enable;
        logic trace_out_enable;
        logic two_wire_tdo_use;
    } runtime_s;

endpackage : cfg_word_pkg

// ---- logic/device_config_word_decoder.sv ----
// Behaviour
// - Window size code 11/10/01/00 gives 25/37.5/50/75 percent clear window.
// - Enable bit set forces watchdog on; clear lets software enable it.
// - Window-disable set means non-window mode, clear means windowed.
// - Postscale code n gives divide by two to the n, up to 1:1048576.
// - Postscale codes above 10100 act as 10100.
// - Switch/monitor: 1x both off, 01 switching only, 00 both on.
// - Peripheral bus divisor codes 00..11 divide system clock by 1,2,4,8.
// - Clock output active when disable bit 0 and oscillator mode 11 or 00.
// - Primary oscillator mode: 11 off, 10 high-speed, 01 crystal, 00 external.
// - Switchover bit set enables two-speed start-up.
// - Secondary oscillator enable bit enables that oscillator.
// - Three-bit initial oscillator select picks one of eight sources.
// - PLL output divisor codes give 1,2,4,8,16,32,64,256.
// - USB PLL bit set disables and bypasses the USB PLL.
// - Both PLL input dividers give 1,2,3,4,5,6,10,12.
// - PLL multiplier codes give 15..21 and 24.
// - Two bits give bus-power and ID pins to USB when set.
// - One-way bits allow a single reconfiguration session when set.
// - Shadow set priority equals the three-bit field value.
// - Low half of word 3 holds a readable user identification value.
// - Lock bits block pin-select and module-disable writes; unlock needed to change.
// - Control register has port enable, trace enable, and TDO use resetting to 1.
// - Module-disable one-way keeps that lock set until device reset.
// - Word 0 port enable bit gives reset value of control register bit.
`timescale 1ns/100ps
module device_config_word_decoder (
    input  wire logic                   clk,          // 250 MHz clock
    input  wire logic                   arst_n,       // Async reset, active low
    input  wire logic [31:0]            cfg_word_0,   // Nonvolatile word 0
    input  wire logic [31:0]            cfg_word_1,   // Nonvolatile word 1
    input  wire logic [31:0]            cfg_word_2,   // Nonvolatile word 2
    input  wire logic [31:0]            cfg_word_3,   // Nonvolatile word 3
    input  wire logic                   wb_cyc_i,     // Wishbone cycle
    input  wire logic                   wb_stb_i,     // Wishbone strobe
    input  wire logic                   wb_we_i,      // Wishbone write
    input  wire logic [5:0]             wb_adr_i,     // Wishbone byte address
    input  wire logic [3:0]             wb_sel_i,     // Wishbone byte selects
    input  wire logic [31:0]            wb_dat_i,     // Wishbone write data
    output logic [31:0]                 wb_dat_o,     // Wishbone read data
    output logic                        wb_ack_o,     // Wishbone acknowledge
    output logic                        cfg_valid,    // Configuration latched
    output cfg_word_pkg::cfg_out_s      cfg_out,      // Decoded defaults
    output cfg_word_pkg::runtime_s      runtime_ctl   // Runtime control bits
);

    typedef struct packed {
        cfg_word_pkg::load_state_e st;
        logic [31:0]               w0;
        logic [31:0]               w1;
        logic [31:0]               w2;
        logic [31:0]               w3;
        cfg_word_pkg::runtime_s    rc;
        logic                      key_a_seen;
        logic                      unlocked;
        logic                      pps_session_used;
        logic [31:0]               rdata;
        logic                      ack;
        cfg_word_pkg::cfg_out_s    dec;
    } state_s;

    state_s s_q;
    state_s s_d;

    // Decode of the latched words
    function automatic cfg_word_pkg::cfg_out_s decode(
        input logic [31:0] w1, input logic [31:0] w2, input logic [31:0] w3);
        cfg_word_pkg::cfg_out_s o;
        logic [1:0] win;
        logic [4:0] ps;
        logic [1:0] cksm;
        logic [1:0] posc;
        logic [2:0] odiv;
        logic [2:0] mul;
        o    = '0;
        win  = w1[cfg_word_pkg::W1_WIN_SIZE_LO +: 2];
        ps   = w1[cfg_word_pkg::W1_POSTSCALE_LO +: 5];
        cksm = w1[cfg_word_pkg::W1_CKSM_LO +: 2];
        posc = w1[cfg_word_pkg::W1_POSC_LO +: 2];
        odiv = w2[cfg_word_pkg::W2_PLL_ODIV_LO +: 3];
        mul  = w2[cfg_word_pkg::W2_PLL_MUL_LO +: 3];
        case (win)
            2'h3:    o.wdog_window_pct_x2 = 7'h32;
            2'h2:    o.wdog_window_pct_x2 = 7'h4B;
            2'h1:    o.wdog_window_pct_x2 = 7'h64;
            default: o.wdog_window_pct_x2 = 7'h96;
        endcase
        o.wdog_hw_enable     = w1[cfg_word_pkg::W1_WDOG_EN];
        o.wdog_sw_may_enable = ~w1[cfg_word_pkg::W1_WDOG_EN];
        o.wdog_windowed      = ~w1[cfg_word_pkg::W1_WIN_DIS];
        o.wdog_postscale_log2 = (ps > cfg_word_pkg::POSTSCALE_MAX) ?
                                cfg_word_pkg::POSTSCALE_MAX : ps;
        o.clk_switch_en    = ~cksm[1];
        o.fail_safe_mon_en = (cksm == 2'h0);
        o.periph_bus_div   = 4'(4'h1 << w1[cfg_word_pkg::W1_PBDIV_LO +: 2]);
        o.clock_output_en  = ~w1[cfg_word_pkg::W1_CLKOUT_DIS] &
                             ((posc == cfg_word_pkg::POSC_DISABLED) ||
                              (posc == cfg_word_pkg::POSC_EXT_CLOCK));
        o.primary_osc_mode = cfg_word_pkg::posc_mode_e'(posc);
        o.two_speed_startup_en = w1[cfg_word_pkg::W1_TWO_SPEED];
        o.secondary_osc_en     = w1[cfg_word_pkg::W1_SOSC_EN];
        o.initial_osc_select   = cfg_word_pkg::osc_src_e'(
                                 w1[cfg_word_pkg::W1_OSC_SEL_LO +: 3]);
        o.pll_out_div = (odiv == 3'h7) ? 9'h100 : 9'(9'h1 << odiv);
        o.usb_pll_bypass = w2[cfg_word_pkg::W2_USB_PLL_DIS];
        o.usb_pll_in_div = in_div(w2[cfg_word_pkg::W2_USB_IDIV_LO +: 3]);
        o.pll_in_div     = in_div(w2[cfg_word_pkg::W2_PLL_IDIV_LO +: 3]);
        o.pll_multiplier = (mul == 3'h7) ? 5'h18 : 5'(5'h0F + mul);
        o.usb_bus_power_to_usb = w3[cfg_word_pkg::W3_VBUS_OWNER];
        o.usb_id_to_usb        = w3[cfg_word_pkg::W3_ID_OWNER];
        o.pin_select_one_way     = w3[cfg_word_pkg::W3_PPS_ONE_WAY];
        o.module_disable_one_way = w3[cfg_word_pkg::W3_PMD_ONE_WAY];
        o.shadow_set_priority = w3[cfg_word_pkg::W3_SRS_LO +: 3];
        o.user_ident_value    = w3[cfg_word_pkg::W3_USERID_LO +: 16];
        return o;
    endfunction : decode

    function automatic logic [3:0] in_div(input logic [2:0] c);
        case (c)
            3'h6:    in_div = 4'hA;
            3'h7:    in_div = 4'hC;
            default: in_div = 4'(4'h1 + c);
        endcase
    endfunction : in_div

    logic        req;
    logic        wr_full;
    logic [31:0] rc_word;

    always_comb begin
        req     = wb_cyc_i & wb_stb_i & ~s_q.ack;
        wr_full = req & wb_we_i & (wb_sel_i == 4'hF);
        rc_word = '0;
        rc_word[cfg_word_pkg::RC_PPS_LOCK]     = s_q.rc.pin_select_lock;
        rc_word[cfg_word_pkg::RC_PMD_LOCK]     = s_q.rc.module_disable_lock;
        rc_word[cfg_word_pkg::RC_TEST_PORT_EN] = s_q.rc.test_port_enable;
        rc_word[cfg_word_pkg::RC_TRACE_EN]     = s_q.rc.trace_out_enable;
        rc_word[cfg_word_pkg::RC_TDO_USE]      = s_q.rc.two_wire_tdo_use;
    end

    always_comb begin
        logic [31:0] wmix;
        logic        new_pps;
        logic        new_pmd;
        wmix    = '0;
        new_pps = 1'b0;
        new_pmd = 1'b0;
        s_d     = s_q;
        s_d.ack = req;
        case (s_q.st)
            cfg_word_pkg::LOAD_IDLE: begin
                // Words captured one clock after reset release
                s_d.w0  = cfg_word_0;
                s_d.w1  = cfg_word_1;
                s_d.w2  = cfg_word_2;
                s_d.w3  = cfg_word_3;
                s_d.dec = decode(cfg_word_1, cfg_word_2, cfg_word_3);
                s_d.rc.test_port_enable = cfg_word_0[cfg_word_pkg::W0_TEST_PORT_EN];
                s_d.st  = cfg_word_pkg::LOAD_RUN;
            end
            cfg_word_pkg::LOAD_RUN: begin
                // Byte-lane merge of a write into the control word
                for (int b = 0; b < 4; b++) begin
                    wmix[8*b +: 8] = wb_sel_i[b] ? wb_dat_i[8*b +: 8] : rc_word[8*b +: 8];
                end
                if (req && wb_we_i && wb_adr_i == cfg_word_pkg::ADDR_RUNTIME_CTRL) begin
                    s_d.rc.test_port_enable = wmix[cfg_word_pkg::RC_TEST_PORT_EN];
                    s_d.rc.trace_out_enable = wmix[cfg_word_pkg::RC_TRACE_EN];
                    s_d.rc.two_wire_tdo_use = wmix[cfg_word_pkg::RC_TDO_USE];
                    new_pps = wmix[cfg_word_pkg::RC_PPS_LOCK];
                    new_pmd = wmix[cfg_word_pkg::RC_PMD_LOCK];
                    if (s_q.unlocked) begin
                        if (!(s_q.rc.pin_select_lock && !new_pps &&
                              s_q.dec.pin_select_one_way && s_q.pps_session_used))
                            s_d.rc.pin_select_lock = new_pps;
                        if (!(s_q.rc.module_disable_lock && !new_pmd &&
                              s_q.dec.module_disable_one_way))
                            s_d.rc.module_disable_lock = new_pmd;
                        if (new_pps)
                            s_d.pps_session_used = 1'b1;
                        s_d.unlocked = 1'b0;
                    end
                end
                if (wr_full && wb_adr_i == cfg_word_pkg::ADDR_UNLOCK) begin
                    s_d.key_a_seen = (wb_dat_i == cfg_word_pkg::UNLOCK_KEY_A);
                    if (s_q.key_a_seen && wb_dat_i == cfg_word_pkg::UNLOCK_KEY_B)
                        s_d.unlocked = 1'b1;
                end
            end
            default: s_d.st = cfg_word_pkg::LOAD_IDLE;
        endcase
        // Read data; words outside the map return zero
        s_d.rdata = cfg_word_pkg::BUS_UNMAPPED;
        if (req && !wb_we_i) begin
            case (wb_adr_i)
                {2'b00, cfg_word_pkg::ADDR_CFG_WORD_0}: s_d.rdata = s_q.w0;
                {2'b00, cfg_word_pkg::ADDR_CFG_WORD_1}: s_d.rdata = s_q.w1;
                {2'b00, cfg_word_pkg::ADDR_CFG_WORD_2}: s_d.rdata = s_q.w2;
                {2'b00, cfg_word_pkg::ADDR_CFG_WORD_3}: s_d.rdata = s_q.w3;
                cfg_word_pkg::ADDR_RUNTIME_CTRL:        s_d.rdata = rc_word;
                default:                                s_d.rdata = cfg_word_pkg::BUS_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q                     <= '0;
            s_q.st                  <= cfg_word_pkg::LOAD_IDLE;
            s_q.rc.two_wire_tdo_use <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        wb_dat_o    = s_q.rdata;
        wb_ack_o    = s_q.ack;
        cfg_valid   = (s_q.st == cfg_word_pkg::LOAD_RUN);
        cfg_out     = s_q.dec;
        runtime_ctl = s_q.rc;
    end

endmodule : device_config_word_decoder

// ---- testbench/device_config_word_decoder_chk.sv ----
`timescale 1ns/100ps
module device_config_word_decoder_chk (
    input wire logic                   clk,         // Clock
    input wire logic                   arst_n,      // Async reset
    input wire logic [31:0]            cfg_word_1,  // Word 1
    input wire logic [31:0]            cfg_word_3,  // Word 3
    input wire logic                   wb_cyc_i,    // Bus cycle
    input wire logic                   wb_stb_i,    // Bus strobe
    input wire logic                   wb_ack_o,    // Bus acknowledge
    input wire logic                   cfg_valid,   // Words latched
    input wire cfg_word_pkg::cfg_out_s cfg_out,     // Decoded defaults
    input wire cfg_word_pkg::runtime_s runtime_ctl  // Control bits
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
    valid_load_a: assert property (!cfg_valid |-> ##2 cfg_valid)
        else $error("configuration not latched after reset");
    cfg_hold_a: assert property (cfg_valid |=> cfg_valid && $stable(cfg_out))
        else $error("decoded defaults changed without reset");
    window_size_a: assert property (cfg_valid |-> cfg_out.wdog_window_pct_x2 ==
        (cfg_word_1[25] ? (cfg_word_1[24] ? 7'h32 : 7'h4B) : (cfg_word_1[24] ? 7'h64 : 7'h96)))
        else $error("window size decode wrong");
    wdog_mode_a: assert property (cfg_valid |-> (cfg_out.wdog_hw_enable == cfg_word_1[23])
        && (cfg_out.wdog_windowed != cfg_word_1[22])) else $error("watchdog mode decode wrong");
    postscale_clamp_a: assert property (cfg_valid |-> cfg_out.wdog_postscale_log2 ==
        ((cfg_word_1[20:16] > 5'h14) ? 5'h14 : cfg_word_1[20:16])) else $error("postscale wrong");
    clk_switch_a: assert property (cfg_valid |-> (cfg_out.clk_switch_en == !cfg_word_1[15])
        && (cfg_out.fail_safe_mon_en == (cfg_word_1[15:14] == 2'h0)))
        else $error("clock switch decode wrong");
    periph_div_a: assert property (cfg_valid |-> cfg_out.periph_bus_div ==
        (4'h1 << cfg_word_1[13:12])) else $error("peripheral divisor wrong");
    clk_out_a: assert property (cfg_valid |-> cfg_out.clock_output_en == (!cfg_word_1[10] &&
        (cfg_word_1[9:8] == 2'h3 || cfg_word_1[9:8] == 2'h0))) else $error("clock output wrong");
    pmd_lock_hold_a: assert property (cfg_valid && cfg_word_3[28]
        && runtime_ctl.module_disable_lock |=> runtime_ctl.module_disable_lock)
        else $error("module disable lock cleared");
endmodule : device_config_word_decoder_chk

// ---- testbench/device_config_word_decoder_tb.sv ----
`timescale 1ns/100ps
module device_config_word_decoder_tb;
    localparam logic [5:0] CTRL = cfg_word_pkg::ADDR_RUNTIME_CTRL;
    localparam logic [5:0] UNLK = cfg_word_pkg::ADDR_UNLOCK;
    logic                   clk = 1'b0;
    logic                   arst_n = 1'b0;
    logic [31:0]            w0 = '0, w1 = '0, w2 = '0, w3 = '0, a1, a2, a3;
    logic                   cyc = 1'b0, stb = 1'b0, we = 1'b0, wb_ack_o, cfg_valid;
    logic [5:0]             adr = '0;
    logic [3:0]             sel = '0;
    logic [31:0]            dat = '0, rdat, rc, lfsr = 32'h0000_0023, wb_dat_o;
    cfg_word_pkg::cfg_out_s cfg_out;
    cfg_word_pkg::runtime_s runtime_ctl;
    int                     num_errors = 0, comparisons = 0, ust = 0;

    always #2 clk = ~clk;

    device_config_word_decoder i_device_config_word_decoder (
        .clk(clk), .arst_n(arst_n), .cfg_word_0(w0), .cfg_word_1(w1), .cfg_word_2(w2),
        .cfg_word_3(w3), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .cfg_valid(cfg_valid), .cfg_out(cfg_out), .runtime_ctl(runtime_ctl));

    function automatic logic [31:0] next_rand(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h8020_0003 : 32'h0000_0000);
    endfunction : next_rand

    function automatic cfg_word_pkg::cfg_out_s model(input logic [31:0] a, b, c);
        int dv[8] = '{1, 2, 3, 4, 5, 6, 10, 12};
        int pct[4] = '{150, 100, 75, 50};
        cfg_word_pkg::cfg_out_s e;
        e = '0;
        e.wdog_hw_enable = a[23];
        e.wdog_sw_may_enable = !a[23];
        e.wdog_windowed = !a[22];
        e.wdog_window_pct_x2 = 7'(pct[a[25:24]]);
        e.wdog_postscale_log2 = (a[20:16] > 5'h14) ? 5'h14 : a[20:16];
        e.clk_switch_en = !a[15];
        e.fail_safe_mon_en = (a[15:14] == 2'h0);
        e.periph_bus_div = 4'(1 << a[13:12]);
        e.clock_output_en = !a[10] && (a[9:8] == 2'h3 || a[9:8] == 2'h0);
        e.primary_osc_mode = cfg_word_pkg::posc_mode_e'(a[9:8]);
        e.two_speed_startup_en = a[7];
        e.secondary_osc_en = a[5];
        e.initial_osc_select = cfg_word_pkg::osc_src_e'(a[2:0]);
        e.pll_out_div = (b[18:16] == 3'h7) ? 9'h100 : 9'(1 << b[18:16]);
        e.usb_pll_bypass = b[15];
        e.usb_pll_in_div = 4'(dv[b[10:8]]);
        e.pll_in_div = 4'(dv[b[2:0]]);
        e.pll_multiplier = (b[6:4] == 3'h7) ? 5'h18 : 5'(15 + b[6:4]);
        e.usb_bus_power_to_usb = c[31];
        e.usb_id_to_usb = c[30];
        e.pin_select_one_way = c[29];
        e.module_disable_one_way = c[28];
        e.shadow_set_priority = c[18:16];
        e.user_ident_value = c[15:0];
        return e;
    endfunction : model

    task automatic print_verdict();
        $display("Errors %0d, comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Classic single cycle; model follows the write at the acknowledged edge
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr;
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            print_verdict();
        end else begin
            rdat = wb_dat_o;
            cyc <= 1'b0;
            stb <= 1'b0;
            if (wr && a == UNLK) begin
                ust = (d == cfg_word_pkg::UNLOCK_KEY_A) ? 1 :
                      (ust == 1 && d == cfg_word_pkg::UNLOCK_KEY_B) ? 2 : 0;
            end
            if (wr && a == CTRL) begin
                rc[3:0] = d[3:0] & 4'hD;
                if (ust == 2 && !(w3[29] && rc[13])) rc[13] = d[13];
                if (ust == 2 && !(w3[28] && rc[12])) rc[12] = d[12];
                ust = 0;
            end
        end
    endtask : bus

    task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        check(rdat, exp);
        if (a == CTRL) check(runtime_ctl, {rc[13], rc[12], rc[3], rc[2], rc[0]});
    endtask : rdchk

    task automatic unlock();
        bus(1'b1, UNLK, cfg_word_pkg::UNLOCK_KEY_A);
        bus(1'b1, UNLK, cfg_word_pkg::UNLOCK_KEY_B);
    endtask : unlock

    initial begin
        #100_000;
        num_errors++;
        print_verdict();
    end

    initial begin
        for (int it = 0; it < 8; it++) begin
            @(posedge clk);
            arst_n <= 1'b0;
            lfsr = next_rand(lfsr);
            a1 = next_rand(lfsr);
            a2 = next_rand(a1);
            a3 = next_rand(a2);
            a3[29:28] = 2'(it);
            if (a1[9:8] == 2'h3 && a1[2:1] == 2'h1) a1[9:8] = 2'h2;
            w0 <= lfsr;
            w1 <= a1;
            w2 <= a2;
            w3 <= a3;
            repeat (10) @(posedge clk);
            arst_n <= 1'b1;
            repeat (2) @(posedge clk);
            rc = {28'h000_0000, w0[2], 3'h1};
            ust = 0;
            check(cfg_valid, 1'b1);
            check(cfg_out, model(w1, w2, w3));
            rdchk(6'h00, w0);
            rdchk(6'h04, w1);
            rdchk(6'h08, w2);
            rdchk(6'h0C, w3);
            rdchk(6'h18, cfg_word_pkg::BUS_UNMAPPED);
            bus(1'b1, 6'h04, ~w1);
            rdchk(6'h04, w1);
            rdchk(CTRL, rc);
            bus(1'b1, CTRL, 32'h0000_3004);
            rdchk(CTRL, rc);
            unlock();
            bus(1'b1, CTRL, 32'h0000_300D);
            rdchk(CTRL, rc);
            unlock();
            bus(1'b1, CTRL, 32'h0000_0001);
            rdchk(CTRL, rc);
        end
        print_verdict();
    end
endmodule : device_config_word_decoder_tb

bind device_config_word_decoder device_config_word_decoder_chk i_device_config_word_decoder_chk (
    .clk(clk), .arst_n(arst_n), .cfg_word_1(cfg_word_1), .cfg_word_3(cfg_word_3),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .cfg_valid(cfg_valid),
    .cfg_out(cfg_out), .runtime_ctl(runtime_ctl));
